/* inc/scs_pkg.sv */
package scs_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0]  SCS_ADDR_SAMPLE_CFG = 8'h4b;
	localparam logic [7:0]  SCS_ADDR_TIMING_TRIM = 8'h4d;
	localparam logic [7:0]  SCS_ADDR_PIN_SYNC = 8'h4f;

	// reset values, reserved bits included
	localparam logic [15:0] SCS_RST_SAMPLE_CFG = 16'h2612;
	localparam logic [15:0] SCS_RST_TIMING_TRIM = 16'h0098;
	localparam logic [15:0] SCS_RST_PIN_SYNC = 16'h2090;

	// field positions
	localparam int          SCS_BIT_CLK_EN = 7;
	localparam int          SCS_LSB_SAMPLE_TRIM = 0;
	localparam int          SCS_LSB_TIMING_TRIM = 0;
	localparam int          SCS_BIT_PIN1_OE = 6;
	localparam int          SCS_BIT_PIN1_IE = 5;
	localparam int          SCS_LSB_SYNC_SRC = 2;

	// divider: four slow clock ticks per divisor count
	localparam logic [1:0]  SCS_DIV_SHIFT = 2'h2;
	localparam logic [17:0] SCS_DIV_CNT_RST = 18'h0_0000;

	// ==========================================================
	// sync source codes
	typedef enum logic [1:0] {
		SCS_SYNC_INTERNAL = 2'b00,
		SCS_SYNC_PIN0     = 2'b01,
		SCS_SYNC_PIN1     = 2'b10,
		SCS_SYNC_RESERVED = 2'b11
	} scs_sync_src_t;

	// one register port access from the serial interface
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} scs_reg_req_t;

endpackage

/* logic/scs_clock_sync.sv */
`timescale 1ns/1ps
module scs_clock_sync (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire scs_pkg::scs_reg_req_t reg_req,
	output logic [15:0]                reg_rdata,
	output logic                       reg_rvalid,
	input  wire logic                  slow_clk_tick,
	input  wire logic [15:0]           sample_rate_divisor,
	input  wire logic                  sample_busy,
	input  wire logic                  aux_pin0_in,
	input  wire logic                  aux_pin1_in,
	input  wire logic                  aux_pin1_drive,
	output logic                       aux_pin1_out,
	output logic                       aux_pin1_oe,
	output logic                       sample_clock_enable,
	output logic [5:0]                 sample_osc_trim,
	output logic [7:0]                 timing_osc_trim,
	output logic                       aux_pin1_input_enable,
	output logic [1:0]                 sample_sync_source,
	output logic                       sample_cycle_start
);
	import scs_pkg::*;

	logic [15:0]   sample_cfg_r;
	logic [15:0]   timing_trim_r;
	logic [15:0]   pin_sync_r;
	logic [17:0]   div_cnt_r;
	logic [17:0]   div_cnt_nxt;
	logic [17:0]   div_limit;
	logic          div_hit;
	logic [2:0]    pin0_sync_r;
	logic [2:0]    pin1_sync_r;
	logic          pin0_edge;
	logic          pin1_edge;
	logic          trig_nxt;
	logic          start_r;
	scs_sync_src_t src;

	// ==========================================================
	// register file
	// all three words are stored whole so reserved bits read back what was written
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sample_cfg_r  <= SCS_RST_SAMPLE_CFG;
			timing_trim_r <= SCS_RST_TIMING_TRIM;
			pin_sync_r    <= SCS_RST_PIN_SYNC;
		end
		else if (reg_req.wr)
		begin
			case (reg_req.addr)
				SCS_ADDR_SAMPLE_CFG:  sample_cfg_r  <= reg_req.wdata;
				SCS_ADDR_TIMING_TRIM: timing_trim_r <= reg_req.wdata;
				SCS_ADDR_PIN_SYNC:    pin_sync_r    <= reg_req.wdata;
				default:              ;
			endcase
		end
	end

	// read data one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd)
			begin
				case (reg_req.addr)
					SCS_ADDR_SAMPLE_CFG:  reg_rdata <= sample_cfg_r;
					SCS_ADDR_TIMING_TRIM: reg_rdata <= timing_trim_r;
					SCS_ADDR_PIN_SYNC:    reg_rdata <= pin_sync_r;
					default:              reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ==========================================================
	// oscillator controls
	// trims go straight to the analogue cells; a larger sample trim is slower
	assign sample_clock_enable   = sample_cfg_r[SCS_BIT_CLK_EN];
	assign sample_osc_trim       = sample_cfg_r[SCS_LSB_SAMPLE_TRIM +: 6];
	assign timing_osc_trim       = timing_trim_r[SCS_LSB_TIMING_TRIM +: 8];
	assign aux_pin1_input_enable = pin_sync_r[SCS_BIT_PIN1_IE];
	assign sample_sync_source    = pin_sync_r[SCS_LSB_SYNC_SRC +: 2];
	assign src                   = scs_sync_src_t'(pin_sync_r[SCS_LSB_SYNC_SRC +: 2]);

	// aux pin 1 drive; the value is registered so the pad sees no glitches
	always_ff @(posedge clk)
	begin
		if (reset)
			aux_pin1_out <= 1'b0;
		else
			aux_pin1_out <= aux_pin1_drive;
	end
	assign aux_pin1_oe = pin_sync_r[SCS_BIT_PIN1_OE];

	// ==========================================================
	// internal divider: one start every 4 * divisor slow ticks
	assign div_limit = {sample_rate_divisor, 2'b00};
	assign div_hit   = slow_clk_tick && (div_cnt_r + 18'h0_0001 >= div_limit);

	always_comb
	begin
		div_cnt_nxt = div_cnt_r;
		if (!sample_clock_enable || src != SCS_SYNC_INTERNAL || div_limit == 18'h0_0000)
			div_cnt_nxt = SCS_DIV_CNT_RST;         // a stopped clock holds the phase at zero
		else if (div_hit)
			div_cnt_nxt = SCS_DIV_CNT_RST;
		else if (slow_clk_tick)
			div_cnt_nxt = div_cnt_r + 18'h0_0001;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			div_cnt_r <= SCS_DIV_CNT_RST;
		else
			div_cnt_r <= div_cnt_nxt;
	end

	// ==========================================================
	// external pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pin0_sync_r <= 3'b000;
			pin1_sync_r <= 3'b000;
		end
		else
		begin
			pin0_sync_r <= {pin0_sync_r[1:0], aux_pin0_in};
			pin1_sync_r <= {pin1_sync_r[1:0], aux_pin1_in && aux_pin1_input_enable};
		end
	end
	assign pin0_edge = pin0_sync_r[1] && !pin0_sync_r[2];
	assign pin1_edge = pin1_sync_r[1] && !pin1_sync_r[2];

	// ==========================================================
	// trigger selection
	// edges seen while a cycle runs are dropped, so cycles never overlap
	always_comb
	begin
		case (src)
			SCS_SYNC_INTERNAL: trig_nxt = sample_clock_enable && div_hit && div_limit != 18'h0_0000;
			SCS_SYNC_PIN0:     trig_nxt = pin0_edge;
			SCS_SYNC_PIN1:     trig_nxt = pin1_edge;
			default:           trig_nxt = 1'b0;       // reserved code starts nothing
		endcase
		if (sample_busy || start_r)
			trig_nxt = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			start_r <= 1'b0;
		else
			start_r <= trig_nxt;
	end
	assign sample_cycle_start = start_r;

	// ==========================================================
	// checks
	a_clk_en_write: assert property (@(posedge clk) disable iff (reset)
		reg_req.wr && reg_req.addr == SCS_ADDR_SAMPLE_CFG |=> sample_clock_enable == $past(reg_req.wdata[7]))
		else $error("sample clock enable did not follow write");
	a_sample_trim_wr: assert property (@(posedge clk) disable iff (reset)
		reg_req.wr && reg_req.addr == SCS_ADDR_SAMPLE_CFG |=> sample_osc_trim == $past(reg_req.wdata[5:0]))
		else $error("sample trim did not follow write");
	a_trim_reset_vals: assert property (@(posedge clk)
		reset |=> sample_osc_trim == 6'h12 && timing_osc_trim == 8'h98)
		else $error("trim reset values wrong");
	a_timing_trim_wr: assert property (@(posedge clk) disable iff (reset)
		reg_req.wr && reg_req.addr == SCS_ADDR_TIMING_TRIM |=> timing_osc_trim == $past(reg_req.wdata[7:0]))
		else $error("timing trim did not follow write");
	a_pin1_oe_wr: assert property (@(posedge clk) disable iff (reset)
		reg_req.wr && reg_req.addr == SCS_ADDR_PIN_SYNC |=> aux_pin1_oe == $past(reg_req.wdata[6]))
		else $error("pin 1 output enable did not follow write");
	a_pin1_ie_gate: assert property (@(posedge clk) disable iff (reset)
		!aux_pin1_input_enable [*3] |-> !pin1_edge)
		else $error("pin 1 edge seen with input disabled");
	a_int_start_en: assert property (@(posedge clk) disable iff (reset)
		sample_cycle_start && $past(src) == SCS_SYNC_INTERNAL |-> $past(sample_clock_enable && slow_clk_tick))
		else $error("internal start without enabled clock tick");
	a_pin0_start: assert property (@(posedge clk) disable iff (reset)
		sample_cycle_start && $past(src) == SCS_SYNC_PIN0 |-> $past(pin0_edge))
		else $error("pin 0 start without pin 0 edge");
	a_pin1_start: assert property (@(posedge clk) disable iff (reset)
		sample_cycle_start && $past(src) == SCS_SYNC_PIN1 |-> $past(pin1_edge))
		else $error("pin 1 start without pin 1 edge");
	a_reserved_idle: assert property (@(posedge clk) disable iff (reset)
		src == SCS_SYNC_RESERVED |=> !sample_cycle_start)
		else $error("start under reserved sync source");
	a_div_wrap: assert property (@(posedge clk) disable iff (reset)
		sample_cycle_start && $past(src) == SCS_SYNC_INTERNAL |-> div_cnt_r == SCS_DIV_CNT_RST)
		else $error("divider did not wrap on start");
	a_busy_blocks: assert property (@(posedge clk) disable iff (reset)
		sample_busy |=> !sample_cycle_start)
		else $error("start while sample cycle busy");

	// ==========================================================
	// register port checks
	// rvalid is a single pulse that answers exactly one read strobe
	a_rvalid_after_rd: assert property (@(posedge clk) disable iff (reset)
		reg_req.rd |=> reg_rvalid)
		else $error("no rvalid after read");
	a_rvalid_no_rd: assert property (@(posedge clk) disable iff (reset)
		!reg_req.rd |=> !reg_rvalid)
		else $error("rvalid without read");

	// read data shows the stored word as it was before any same-cycle write
	a_rd_sample_cfg: assert property (@(posedge clk) disable iff (reset)
		reg_req.rd && reg_req.addr == SCS_ADDR_SAMPLE_CFG |=> reg_rdata == $past(sample_cfg_r))
		else $error("sample config read data wrong");
	a_rd_timing_trim: assert property (@(posedge clk) disable iff (reset)
		reg_req.rd && reg_req.addr == SCS_ADDR_TIMING_TRIM |=> reg_rdata == $past(timing_trim_r))
		else $error("timing trim read data wrong");
	a_rd_pin_sync: assert property (@(posedge clk) disable iff (reset)
		reg_req.rd && reg_req.addr == SCS_ADDR_PIN_SYNC |=> reg_rdata == $past(pin_sync_r))
		else $error("pin and sync read data wrong");

	// unmapped reads give zero, and read data holds between reads
	a_rd_unmapped: assert property (@(posedge clk) disable iff (reset)
		reg_req.rd && reg_req.addr != SCS_ADDR_SAMPLE_CFG && reg_req.addr != SCS_ADDR_TIMING_TRIM &&
		reg_req.addr != SCS_ADDR_PIN_SYNC |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (@(posedge clk) disable iff (reset)
		!reg_req.rd |=> $stable(reg_rdata))
		else $error("read data moved without read");

	// remaining pin and sync fields follow their write
	a_pin1_ie_wr: assert property (@(posedge clk) disable iff (reset)
		reg_req.wr && reg_req.addr == SCS_ADDR_PIN_SYNC |=> aux_pin1_input_enable == $past(reg_req.wdata[5]))
		else $error("pin 1 input enable did not follow write");
	a_sync_src_wr: assert property (@(posedge clk) disable iff (reset)
		reg_req.wr && reg_req.addr == SCS_ADDR_PIN_SYNC |=> sample_sync_source == $past(reg_req.wdata[3:2]))
		else $error("sync source did not follow write");

	// a write elsewhere must leave a register untouched
	a_sample_cfg_keep: assert property (@(posedge clk) disable iff (reset)
		!(reg_req.wr && reg_req.addr == SCS_ADDR_SAMPLE_CFG) |=> $stable(sample_cfg_r))
		else $error("sample config changed without write");
	a_timing_keep: assert property (@(posedge clk) disable iff (reset)
		!(reg_req.wr && reg_req.addr == SCS_ADDR_TIMING_TRIM) |=> $stable(timing_trim_r))
		else $error("timing trim changed without write");
	a_pin_sync_keep: assert property (@(posedge clk) disable iff (reset)
		!(reg_req.wr && reg_req.addr == SCS_ADDR_PIN_SYNC) |=> $stable(pin_sync_r))
		else $error("pin and sync changed without write");

	// reset leaves pin 1 undriven, the clock stopped and internal pacing chosen
	a_reset_fields: assert property (@(posedge clk)
		reset |=> !aux_pin1_oe && !aux_pin1_input_enable && sample_sync_source == 2'b00 &&
		!sample_clock_enable && !sample_cycle_start)
		else $error("control fields wrong after reset");
	a_pin1_out_follow: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> aux_pin1_out == $past(aux_pin1_drive))
		else $error("pin 1 drive not registered");

	// ==========================================================
	// pacing checks
	// a start is a one-cycle pulse, never two in a row
	a_start_single: assert property (@(posedge clk) disable iff (reset)
		sample_cycle_start |=> !sample_cycle_start)
		else $error("start longer than one cycle");
	a_clk_off_idle: assert property (@(posedge clk) disable iff (reset)
		!sample_clock_enable && src == SCS_SYNC_INTERNAL |=> !sample_cycle_start)
		else $error("internal start with clock stopped");

	// the divider phase rests at zero while stopped and, with internal pacing, moves one per tick until it wraps at the limit
	a_div_held_off: assert property (@(posedge clk) disable iff (reset)
		!sample_clock_enable |=> div_cnt_r == SCS_DIV_CNT_RST)
		else $error("divider ran with clock stopped");
	a_div_count_tick: assert property (@(posedge clk) disable iff (reset)
		sample_clock_enable && src == SCS_SYNC_INTERNAL && slow_clk_tick && !div_hit &&
		div_limit != 18'h0_0000 |=> div_cnt_r == $past(div_cnt_r) + 18'h0_0001)
		else $error("divider did not count a tick");
	a_div_no_tick: assert property (@(posedge clk) disable iff (reset)
		sample_clock_enable && src == SCS_SYNC_INTERNAL && !slow_clk_tick |=> $stable(div_cnt_r))
		else $error("divider moved without a tick");

	// a trigger that is not blocked starts a cycle on the next clock
	a_int_latency: assert property (@(posedge clk) disable iff (reset)
		src == SCS_SYNC_INTERNAL && sample_clock_enable && div_hit && div_limit != 18'h0_0000 &&
		!sample_busy && !sample_cycle_start |=> sample_cycle_start)
		else $error("internal hit gave no start");
	a_pin0_latency: assert property (@(posedge clk) disable iff (reset)
		src == SCS_SYNC_PIN0 && pin0_edge && !sample_busy && !sample_cycle_start |=> sample_cycle_start)
		else $error("pin 0 edge gave no start");
	a_pin1_latency: assert property (@(posedge clk) disable iff (reset)
		src == SCS_SYNC_PIN1 && pin1_edge && !sample_busy && !sample_cycle_start |=> sample_cycle_start)
		else $error("pin 1 edge gave no start");

	// without an edge on the chosen pin nothing starts
	a_pin0_quiet: assert property (@(posedge clk) disable iff (reset)
		src == SCS_SYNC_PIN0 && !pin0_edge |=> !sample_cycle_start)
		else $error("pin 0 start without edge");
	a_pin1_quiet: assert property (@(posedge clk) disable iff (reset)
		src == SCS_SYNC_PIN1 && !pin1_edge |=> !sample_cycle_start)
		else $error("pin 1 start without edge");

endmodule

/* verif/scs_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host side of the register strobe port
module scs_host_model (
	input  wire logic                  clk,
	output scs_pkg::scs_reg_req_t      reg_req,
	input  wire logic [15:0]           reg_rdata,
	input  wire logic                  reg_rvalid
);
	import scs_pkg::*;
	// idle port: strobes low so nothing is taken by accident
	initial reg_req = '0;
	// write strobe stands exactly one rising edge, launched at the falling edge
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
	begin
		@(negedge clk);
		reg_req = '{1'b1, 1'b0, a, v};
		@(negedge clk);
		reg_req = '0;
	end
	endtask
	// rvalid stands for the one cycle after the strobe edge and read data holds until the next read; take them inside it
	task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic ok);
	begin
		@(negedge clk);
		reg_req = '{1'b0, 1'b1, a, 16'h0000};
		@(negedge clk);
		v = reg_rdata;
		ok = reg_rvalid;
		reg_req = '0;
	end
	endtask
endmodule

/* verif/scs_clock_sync_test.sv */
`timescale 1ns/1ps
module scs_clock_sync_test;
	import scs_pkg::*;
	logic               clk = 0, reset = 1, tick = 0, p0 = 0, p1 = 0, ok, busy = 0, drv = 0;
	logic [15:0]        div = 16'h0002, rdata, d;
	logic               rvalid, p1_out, p1_oe, en, ie, start;
	logic [5:0]         s_trim;
	logic [7:0]         t_trim;
	logic [1:0]         src;
	scs_reg_req_t       req;
	int                 n_mismatch = 0, check_count = 0, n_start = 0, cyc = 0;

	always #50 clk = ~clk;
	scs_host_model scs_host_model_i (.clk(clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
	scs_clock_sync scs_clock_sync_i (.clk(clk), .reset(reset), .reg_req(req), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .slow_clk_tick(tick), .sample_rate_divisor(div), .sample_busy(busy),
		.aux_pin0_in(p0), .aux_pin1_in(p1), .aux_pin1_drive(drv), .aux_pin1_out(p1_out),
		.aux_pin1_oe(p1_oe), .sample_clock_enable(en), .sample_osc_trim(s_trim),
		.timing_osc_trim(t_trim), .aux_pin1_input_enable(ie), .sample_sync_source(src),
		.sample_cycle_start(start));

	// ==========================================================
	// start counting and hang guard (whole run needs well under 1000 cycles)
	always @(posedge clk)
	begin
		cyc++;
		if (start === 1'b1)
			n_start++;
		if (cyc == 2000)
		begin
			n_mismatch++;
			report_and_stop;
		end
	end

	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	begin
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
	begin
		scs_host_model_i.rd(a, d, ok);
		chk(d, exp);
		chk({15'h0000, ok}, 16'h0001);
	end
	endtask
	// ticks spaced three clocks apart, like a slow oscillator seen from here
	task automatic ticks(input int n);
	begin
		repeat (n)
		begin
			@(negedge clk);
			tick = 1;
			@(negedge clk);
			tick = 0;
			@(negedge clk);
		end
	end
	endtask
	task automatic report_and_stop;
	begin
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	// ==========================================================
	// test sequence
	initial
	begin
		repeat (3) @(negedge clk);
		reset = 0;
		rchk(SCS_ADDR_SAMPLE_CFG, 16'h2612);
		rchk(SCS_ADDR_TIMING_TRIM, 16'h0098);
		rchk(SCS_ADDR_PIN_SYNC, 16'h2090);
		rchk(8'h4c, 16'h0000);
		chk({7'h00, en, p1_oe, ie, s_trim}, 16'h0012);
		chk({6'h00, src, t_trim}, 16'h0098);
		$display("reset values done");
		// trims at both ends of their ranges
		scs_host_model_i.wr(SCS_ADDR_SAMPLE_CFG, 16'h26bf);
		chk({9'h000, en, s_trim}, 16'h007f);
		scs_host_model_i.wr(SCS_ADDR_SAMPLE_CFG, 16'h2680);
		chk({9'h000, en, s_trim}, 16'h0040);
		scs_host_model_i.wr(SCS_ADDR_TIMING_TRIM, 16'h0000);
		chk({8'h00, t_trim}, 16'h0000);
		scs_host_model_i.wr(SCS_ADDR_TIMING_TRIM, 16'h00ff);
		rchk(SCS_ADDR_TIMING_TRIM, 16'h00ff);
		chk({8'h00, t_trim}, 16'h00ff);
		// pin 1 as input (pair 01), then as output
		scs_host_model_i.wr(SCS_ADDR_PIN_SYNC, 16'h20b0);
		chk({14'h0000, p1_oe, ie}, 16'h0001);
		scs_host_model_i.wr(SCS_ADDR_PIN_SYNC, 16'h20d0);
		chk({14'h0000, p1_oe, ie}, 16'h0002);
		$display("trim and pin fields done");
		// internal pacing: divisor 2 means one start per 8 ticks
		scs_host_model_i.wr(8'h38, 16'h0000);
		scs_host_model_i.wr(SCS_ADDR_PIN_SYNC, 16'h2090);
		scs_host_model_i.wr(SCS_ADDR_SAMPLE_CFG, 16'h2692);
		n_start = 0;
		ticks(16);
		chk(16'(n_start), 16'h0002);
		scs_host_model_i.wr(SCS_ADDR_SAMPLE_CFG, 16'h2612);
		ticks(16);
		chk(16'(n_start), 16'h0002);
		$display("internal pacing done");
		// each external code, both pins pulsed; long highs still start once
		scs_host_model_i.wr(8'h38, 16'h4000);
		for (int k = 1; k < 4; k++)
		begin
			scs_host_model_i.wr(SCS_ADDR_PIN_SYNC, 16'h20b0 | (16'(k) << 2));
			n_start = 0;
			p0 = 1;
			repeat (5) @(negedge clk);
			p0 = 0;
			repeat (6) @(negedge clk);
			p1 = 1;
			repeat (5) @(negedge clk);
			p1 = 0;
			repeat (6) @(negedge clk);
			chk(16'(n_start), (k == 3) ? 16'h0000 : 16'h0001);
		end
		// a pin edge while a cycle runs is dropped
		scs_host_model_i.wr(SCS_ADDR_PIN_SYNC, 16'h20b4);
		busy = 1;
		n_start = 0;
		p0 = 1;
		repeat (5) @(negedge clk);
		p0 = 0;
		repeat (6) @(negedge clk);
		busy = 0;
		chk(16'(n_start), 16'h0000);
		// pin 1 drive value reaches the pad one clock later
		drv = 1;
		@(negedge clk);
		chk({15'h0000, p1_out}, 16'h0001);
		$display("external sync done");
		report_and_stop;
	end
endmodule
